/* include/svw_pkg.sv */
// shared constants and types for the supervisor reset and watchdog block
package svw_pkg;
  // ***************
  // clock and times
  // ***************
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PS_PER_MS     = 1000000000;
  localparam int unsigned PS_PER_US     = 1000000;
  localparam int unsigned MS_CYCLES     = PS_PER_MS / CLK_PERIOD_PS;
  localparam int unsigned T_RF_US       = 10;
  localparam int unsigned RF_CYCLES     = (T_RF_US * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_RD_MS       = 10;
  localparam int unsigned RD_CYCLES     = T_RD_MS * MS_CYCLES;
  localparam int unsigned MS_W          = 10;
  localparam logic [9:0]  LW_MS         = 10'h0_0C8;
  localparam int unsigned CLOSED_PCT    = 60;
  localparam int unsigned FULL_PCT      = 100;
  // ***************
  // watchdog byte layout, defaults, codes
  // ***************
  localparam int unsigned PER_LSB        = 0;
  localparam int unsigned PER_W          = 3;
  localparam int unsigned TYPE_BIT       = 4;
  localparam logic        TYPE_DEFAULT   = 1'h0;
  localparam logic [2:0]  PERIOD_DEFAULT = 3'h3;
  localparam logic [1:0]  MODE_SOFT      = 2'h3;
  localparam logic [1:0]  CFG2_CODE      = 2'h1;
  localparam logic [1:0]  FAIL_SAT_CFG2  = 2'h1;
  localparam logic [1:0]  FAIL_SAT_OTHER = 2'h2;
  localparam logic [1:0]  SYNC_INIT      = 2'h3;

  typedef enum logic [2:0] {
    MODE_INIT, MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE, MODE_DEV
  } svw_mode_t;

  typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_RUN} svw_wd_t;

  // period field value 0..6 is setting 1..7; value 7 is treated as the longest
  function automatic logic [9:0] period_ms(input logic [2:0] f);
    case (f)
      3'h0:    period_ms = 10'h0_00A;
      3'h1:    period_ms = 10'h0_014;
      3'h2:    period_ms = 10'h0_032;
      3'h3:    period_ms = 10'h0_064;
      3'h4:    period_ms = 10'h0_0C8;
      3'h5:    period_ms = 10'h1_F4;
      default: period_ms = 10'h3_E8;
    endcase
  endfunction : period_ms
endpackage : svw_pkg

/* rtl/svw_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module svw_sync #(
  parameter int unsigned    W    = 2,
  parameter logic [W-1:0]   INIT = '1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // async in, filtered out
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < W; i++) begin
      // a change counts only once stages two and three agree
      if (s2_reg[i] == s3_reg[i]) begin
        q_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg  <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule : svw_sync

/* rtl/svw_reset_gen.sv */
// reset output generator: event filter and release delay
`timescale 1ns/1ps
module svw_reset_gen #(
  parameter int unsigned RF_CYCLES = svw_pkg::RF_CYCLES,
  parameter int unsigned RD_CYCLES = svw_pkg::RD_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // events
  input  wire logic uv,
  input  wire logic kick,
  // reset pin side
  output logic      reset_out_n,
  output logic      released
);
  localparam int unsigned FW = $clog2(RF_CYCLES + 1);
  localparam int unsigned DW = $clog2(RD_CYCLES + 1);
  localparam logic [FW-1:0] RF_MAX = FW'(RF_CYCLES);
  localparam logic [DW-1:0] RD_MAX = DW'(RD_CYCLES - 1);

  logic [FW-1:0] filt_reg, filt_next;
  logic [DW-1:0] dly_reg, dly_next;
  logic          rn_reg, rn_next, rel_reg, rel_next, ev;

  always_comb begin
    filt_next = uv ? ((filt_reg == RF_MAX) ? filt_reg : filt_reg + 1'b1) : '0;
    ev        = kick | (uv & (filt_reg == RF_MAX));
    rn_next   = rn_reg;
    dly_next  = dly_reg;
    if (ev) begin
      rn_next  = 1'b0;
      dly_next = '0;
    end else if (!rn_reg) begin
      // held low for the event plus one full delay, also at power up
      if (dly_reg == RD_MAX) begin
        rn_next  = 1'b1;
        dly_next = '0;
      end else begin
        dly_next = dly_reg + 1'b1;
      end
    end
    rel_next = ~rn_reg & rn_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_reg <= '0;
      dly_reg  <= '0;
      rn_reg   <= 1'b0;
      rel_reg  <= 1'b0;
    end else begin
      filt_reg <= filt_next;
      dly_reg  <= dly_next;
      rn_reg   <= rn_next;
      rel_reg  <= rel_next;
    end
  end

  assign reset_out_n = rn_reg;
  assign released    = rel_reg;

  property p_kick_low;
    @(posedge clk) disable iff (rst) kick |=> !reset_out_n;
  endproperty
  a_kick_low: assert property (p_kick_low) else $error("reset not asserted on kick");
endmodule : svw_reset_gen

/* rtl/svw_watchdog.sv */
// supervisor top: reset output, soft reset and watchdog
`timescale 1ns/1ps
module svw_watchdog #(
  parameter int unsigned MS_CYCLES = svw_pkg::MS_CYCLES,
  parameter int unsigned RF_CYCLES = svw_pkg::RF_CYCLES,
  parameter int unsigned RD_CYCLES = svw_pkg::RD_CYCLES
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // device state and configuration
  input  wire svw_pkg::svw_mode_t dev_mode,
  input  wire logic              restart_on_fail,
  input  wire logic [1:0]        fail_config,
  input  wire logic              soft_reset_pulses_rst,
  input  wire logic              stop_disable_enable_a,
  input  wire logic              stop_disable_enable_b,
  // pins from outside the clock domain
  input  wire logic              chip_select_n,
  input  wire logic              supply_low,
  // decoded spi writes
  input  wire logic              wd_wr_valid,
  input  wire logic [7:0]        wd_wr_data,
  input  wire logic              mode_wr_valid,
  input  wire logic [1:0]        mode_wr_field,
  // reset pin and events
  output logic                   reset_out_n,
  output logic                   soft_reset_pulse,
  output logic                   watchdog_fail_count_pulse,
  output logic                   watchdog_fail_count_restart,
  output logic                   spi_fail_pulse,
  output logic                   stop_disable_clear,
  // watchdog status
  output logic                   watchdog_type_select,
  output logic [2:0]             watchdog_period_field,
  output logic [1:0]             watchdog_fail_count,
  output svw_pkg::svw_wd_t       wd_state
);
  localparam int unsigned PW = $clog2(MS_CYCLES);
  localparam logic [PW-1:0] PRE_MAX = PW'(MS_CYCLES - 1);

  function automatic logic [9:0] closed_ms(input logic [9:0] p);
    closed_ms = 10'((32'(p) * svw_pkg::CLOSED_PCT) / svw_pkg::FULL_PCT);
  endfunction : closed_ms

  // ***************
  // pins and reset output
  // ***************
  logic [1:0] sync_q;
  logic       cs_n_s, uv_s, released, kick_reg, kick_next;

  svw_sync #(.W(2), .INIT(svw_pkg::SYNC_INIT)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({chip_select_n, supply_low}),
    .q   (sync_q)
  );
  assign cs_n_s = sync_q[1];
  assign uv_s   = sync_q[0];

  svw_reset_gen #(.RF_CYCLES(RF_CYCLES), .RD_CYCLES(RD_CYCLES)) u_rgen (
    .clk         (clk),
    .rst         (rst),
    .uv          (uv_s),
    .kick        (kick_reg),
    .reset_out_n (reset_out_n),
    .released    (released)
  );

  // ***************
  // watchdog state
  // ***************
  svw_pkg::svw_wd_t   st_reg, st_next;
  svw_pkg::svw_mode_t mprev_reg;
  logic [PW-1:0] pre_reg, pre_next;
  logic [9:0]    ms_reg, ms_next, limit;
  logic [7:0]    stage_reg, stage_next;
  logic [2:0]    per_reg, per_next;
  logic [1:0]    cnt_reg, cnt_next, sat;
  logic type_reg, type_next, pend_reg, pend_next, csp_reg;
  logic cause_reg, cause_next, soft_reg, soft_next, fail_reg, fail_next;
  logic frs_reg, frs_next, spie_reg, spie_next, clr_reg, clr_next;
  logic cs_rise, trig, tick, expire, soft_cmd, stop_dis, is_norm, is_stop;
  logic do_fail, restart, enter_norm, off_cond;

  always_comb begin
    st_next    = st_reg;
    pre_next   = (pre_reg == PRE_MAX) ? '0 : pre_reg + 1'b1;
    ms_next    = ms_reg;
    stage_next = stage_reg;
    per_next   = per_reg;
    type_next  = type_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg;
    cause_next = cause_reg;
    frs_next   = frs_reg;
    soft_next  = 1'b0;
    fail_next  = 1'b0;
    spie_next  = 1'b0;
    clr_next   = 1'b0;
    kick_next  = 1'b0;
    do_fail    = 1'b0;
    restart    = 1'b0;
    is_norm    = dev_mode == svw_pkg::MODE_NORMAL;
    is_stop    = dev_mode == svw_pkg::MODE_STOP;
    stop_dis   = stop_disable_enable_a & stop_disable_enable_b & ~clr_reg;
    tick       = pre_reg == PRE_MAX;
    sat        = (fail_config == svw_pkg::CFG2_CODE) ? svw_pkg::FAIL_SAT_CFG2
                                                     : svw_pkg::FAIL_SAT_OTHER;
    limit      = (st_reg == svw_pkg::WD_LONG) ? svw_pkg::LW_MS
                                              : svw_pkg::period_ms(per_reg);
    expire     = tick & (ms_reg == limit - 10'h0_001) & (st_reg != svw_pkg::WD_OFF);
    if (tick) begin
      ms_next = ms_reg + 10'h0_001;
    end
    // trigger only acts when chip select returns high
    cs_rise = cs_n_s & ~csp_reg;
    trig    = cs_rise & pend_reg;
    if (cs_rise) begin
      pend_next = 1'b0;
    end
    if (wd_wr_valid) begin
      if (^wd_wr_data) begin
        spie_next = 1'b1;
      end else begin
        pend_next  = 1'b1;
        stage_next = wd_wr_data;
      end
    end
    soft_cmd   = mode_wr_valid & (mode_wr_field == svw_pkg::MODE_SOFT) & (is_norm | is_stop);
    enter_norm = is_norm & ((mprev_reg == svw_pkg::MODE_SLEEP)
                 | (mprev_reg == svw_pkg::MODE_RESTART)
                 | ((mprev_reg == svw_pkg::MODE_STOP) & stop_dis));
    off_cond   = (dev_mode == svw_pkg::MODE_SLEEP) | (dev_mode == svw_pkg::MODE_RESTART)
                 | (dev_mode == svw_pkg::MODE_DEV) | (dev_mode == svw_pkg::MODE_FAILSAFE)
                 | (is_stop & stop_dis) | ~reset_out_n;
    if (is_norm) begin
      cause_next = 1'b0;
    end
    if (soft_cmd) begin
      // defaults restored; without a reset pulse the long window starts now
      type_next = svw_pkg::TYPE_DEFAULT;
      per_next  = svw_pkg::PERIOD_DEFAULT;
      cnt_next  = '0;
      pend_next = 1'b0;
      soft_next = 1'b1;
      kick_next = soft_reset_pulses_rst;
      st_next   = soft_reset_pulses_rst ? svw_pkg::WD_OFF : svw_pkg::WD_LONG;
      restart   = 1'b1;
    end else if (released & (dev_mode != svw_pkg::MODE_DEV)
                 & (dev_mode != svw_pkg::MODE_SLEEP) & (dev_mode != svw_pkg::MODE_FAILSAFE)) begin
      st_next = svw_pkg::WD_LONG;
      restart = 1'b1;
    end else if (enter_norm | (is_stop & stop_dis & trig)) begin
      st_next  = svw_pkg::WD_LONG;
      restart  = 1'b1;
      clr_next = stop_dis;
    end else if (off_cond) begin
      st_next = svw_pkg::WD_OFF;
      if ((dev_mode == svw_pkg::MODE_SLEEP) | (is_stop & stop_dis)
          | ((dev_mode == svw_pkg::MODE_FAILSAFE) & ~cause_reg)) begin
        cnt_next = '0;
      end
    end else begin
      case (st_reg)
        svw_pkg::WD_LONG: begin
          if (trig) begin
            st_next = svw_pkg::WD_RUN;
            restart = 1'b1;
          end else if (expire) begin
            do_fail = 1'b1;
          end
        end
        svw_pkg::WD_RUN: begin
          if (trig & type_reg & (ms_reg < closed_ms(svw_pkg::period_ms(per_reg)))) begin
            do_fail = 1'b1;
          end else if (trig) begin
            restart = 1'b1;
          end else if (expire) begin
            do_fail = 1'b1;
          end
        end
        default: begin
          st_next = svw_pkg::WD_OFF;
        end
      endcase
      if (trig & ~do_fail) begin
        cnt_next = '0;
        if (is_norm) begin
          // new timing takes effect with the restart it causes
          type_next = stage_next[svw_pkg::TYPE_BIT];
          per_next  = stage_next[svw_pkg::PER_LSB +: svw_pkg::PER_W];
        end
      end
    end
    if (do_fail) begin
      st_next    = svw_pkg::WD_OFF;
      fail_next  = 1'b1;
      kick_next  = 1'b1;
      cause_next = 1'b1;
      frs_next   = restart_on_fail;
      cnt_next   = (cnt_reg >= sat) ? sat : cnt_reg + 2'h1;
    end
    if (restart) begin
      pre_next = '0;
      ms_next  = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg    <= svw_pkg::WD_OFF;
      mprev_reg <= svw_pkg::MODE_INIT;
      pre_reg   <= '0;
      ms_reg    <= '0;
      stage_reg <= '0;
      per_reg   <= svw_pkg::PERIOD_DEFAULT;
      type_reg  <= svw_pkg::TYPE_DEFAULT;
      cnt_reg   <= '0;
      pend_reg  <= 1'b0;
      csp_reg   <= 1'b1;
      cause_reg <= 1'b0;
      soft_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      frs_reg   <= 1'b0;
      spie_reg  <= 1'b0;
      clr_reg   <= 1'b0;
      kick_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      mprev_reg <= dev_mode;
      pre_reg   <= pre_next;
      ms_reg    <= ms_next;
      stage_reg <= stage_next;
      per_reg   <= per_next;
      type_reg  <= type_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      csp_reg   <= cs_n_s;
      cause_reg <= cause_next;
      soft_reg  <= soft_next;
      fail_reg  <= fail_next;
      frs_reg   <= frs_next;
      spie_reg  <= spie_next;
      clr_reg   <= clr_next;
      kick_reg  <= kick_next;
    end
  end

  assign soft_reset_pulse      = soft_reg;
  assign watchdog_fail_count_pulse         = fail_reg;
  assign watchdog_fail_count_restart       = frs_reg;
  assign spi_fail_pulse        = spie_reg;
  assign stop_disable_clear    = clr_reg;
  assign watchdog_type_select  = type_reg;
  assign watchdog_period_field = per_reg;
  assign watchdog_fail_count   = cnt_reg;
  assign wd_state              = st_reg;

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_parity;
    wd_wr_valid && ^wd_wr_data |=> spi_fail_pulse;
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not flagged");

  property p_sat;
    watchdog_fail_count_pulse && fail_config == svw_pkg::CFG2_CODE |-> watchdog_fail_count <= 2'h1;
  endproperty
  a_sat: assert property (p_sat) else $error("fail count beyond limit");

  property p_soft_ign;
    mode_wr_valid && mode_wr_field == svw_pkg::MODE_SOFT && !is_norm && !is_stop
      |=> !soft_reset_pulse;
  endproperty
  a_soft_ign: assert property (p_soft_ign) else $error("soft reset not ignored");

  property p_soft;
    mode_wr_valid && mode_wr_field == svw_pkg::MODE_SOFT && is_norm
      |=> soft_reset_pulse && watchdog_period_field == svw_pkg::PERIOD_DEFAULT
          && !watchdog_type_select;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset defaults missing");

  property p_dev;
    (dev_mode == svw_pkg::MODE_DEV) [*2] |=> !watchdog_fail_count_pulse;
  endproperty
  a_dev: assert property (p_dev) else $error("failure in development mode");

  property p_start;
    st_reg == svw_pkg::WD_OFF ##1 st_reg == svw_pkg::WD_LONG |-> ms_reg == 10'h0_000;
  endproperty
  a_start: assert property (p_start) else $error("long window not from zero");

  property p_closed;
    st_reg == svw_pkg::WD_RUN && trig && type_reg && is_norm && !mode_wr_valid
      && reset_out_n && !released && ms_reg < closed_ms(svw_pkg::period_ms(per_reg))
      |=> watchdog_fail_count_pulse ##1 !reset_out_n;
  endproperty
  a_closed: assert property (p_closed) else $error("closed window trigger missed");

  property p_sleep;
    dev_mode == svw_pkg::MODE_SLEEP |=> st_reg == svw_pkg::WD_OFF && watchdog_fail_count == 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("watchdog alive in sleep");

  property p_good;
    st_reg == svw_pkg::WD_RUN && trig && !type_reg && is_norm && !mode_wr_valid
      && reset_out_n && !released |=> watchdog_fail_count == 2'h0 && ms_reg == 10'h0_000;
  endproperty
  a_good: assert property (p_good) else $error("good trigger not served");
endmodule : svw_watchdog

/* verification/svw_host.sv */
// host model that serves the watchdog over the serial link
`timescale 1ns/1ps
module svw_host (
  // clock
  input  wire logic  clk,
  // frame side
  output logic       chip_select_n,
  output logic       wd_wr_valid,
  output logic [7:0] wd_wr_data
);
  logic sclk;

  initial begin
    chip_select_n = 1'b1;
    wd_wr_valid   = 1'b0;
    wd_wr_data    = 8'h00;
    sclk          = 1'b0;
  end

  // parity kept in bit 7; bad set only when a test asks for a refusal
  task automatic serve(input logic [6:0] pay, input logic bad);
    logic [7:0] d;
    d = {^pay ^ bad, pay};
    @(posedge clk);
    chip_select_n <= 1'b0;
    // link clock runs only inside the frame
    repeat (16) #24 sclk = ~sclk;
    @(posedge clk);
    wd_wr_valid <= 1'b1;
    wd_wr_data  <= d;
    @(posedge clk);
    wd_wr_valid <= 1'b0;
    wd_wr_data  <= ~d;
    @(posedge clk);
    chip_select_n <= 1'b1;
  endtask : serve
endmodule : svw_host

/* verification/svw_watchdog_tb.sv */
// self-checking bench for the supervisor reset and watchdog block
`timescale 1ns/1ps
module svw_watchdog_tb;
  localparam int MSC = 20;
  localparam int RDC = 50;
  localparam int LWC = 200 * MSC;
  typedef struct packed {
    logic [6:0] pay;
    logic       bad;
    logic [2:0] per;
  } svw_row_t;
  // ****************
  // signals
  // ****************
  logic               clk                   = 1'b0;
  logic               rst                   = 1'b1;
  svw_pkg::svw_mode_t dev_mode              = svw_pkg::MODE_NORMAL;
  logic               restart_on_fail       = 1'b1;
  logic [1:0]         fail_config           = 2'h0;
  logic               soft_reset_pulses_rst = 1'b1;
  logic               supply_low            = 1'b0;
  logic               mode_wr_valid         = 1'b0;
  logic [1:0]         mode_wr_field         = 2'h0;
  logic               chip_select_n, wd_wr_valid;
  logic [7:0]         wd_wr_data;
  logic               reset_out_n, soft_reset_pulse, watchdog_fail_count_pulse;
  logic               watchdog_fail_count_restart, spi_fail_pulse, watchdog_type_select;
  logic [2:0]         watchdog_period_field;
  logic [1:0]         watchdog_fail_count;
  svw_pkg::svw_wd_t   wd_state;
  logic               spi_seen, fail_seen, soft_seen, clr_seen, stop_disable_clear;
  logic [1:0]         stop_dis              = 2'h0;
  int                 failures   = 0;
  int                 n_compared = 0;
  int                 n;
  svw_row_t           rows [8]   = '{'{7'h0E, 1'b1, 3'h3}, '{7'h06, 1'b0, 3'h6},
                                     '{7'h05, 1'b0, 3'h5}, '{7'h0C, 1'b0, 3'h4},
                                     '{7'h0B, 1'b0, 3'h3}, '{7'h02, 1'b0, 3'h2},
                                     '{7'h01, 1'b0, 3'h1}, '{7'h00, 1'b0, 3'h0}};

  always #2.5 clk = ~clk;

  svw_host host (.clk(clk), .chip_select_n(chip_select_n), .wd_wr_valid(wd_wr_valid),
                 .wd_wr_data(wd_wr_data));

  svw_watchdog #(.MS_CYCLES(MSC), .RF_CYCLES(8), .RD_CYCLES(RDC)) DUT (
    .clk(clk), .rst(rst), .dev_mode(dev_mode), .restart_on_fail(restart_on_fail),
    .fail_config(fail_config), .soft_reset_pulses_rst(soft_reset_pulses_rst),
    .stop_disable_enable_a(stop_dis[1]), .stop_disable_enable_b(stop_dis[0]),
    .chip_select_n(chip_select_n), .supply_low(supply_low), .wd_wr_valid(wd_wr_valid),
    .wd_wr_data(wd_wr_data), .mode_wr_valid(mode_wr_valid), .mode_wr_field(mode_wr_field),
    .reset_out_n(reset_out_n), .soft_reset_pulse(soft_reset_pulse),
    .watchdog_fail_count_pulse(watchdog_fail_count_pulse), .watchdog_fail_count_restart(watchdog_fail_count_restart),
    .spi_fail_pulse(spi_fail_pulse), .stop_disable_clear(stop_disable_clear),
    .watchdog_type_select(watchdog_type_select),
    .watchdog_period_field(watchdog_period_field),
    .watchdog_fail_count(watchdog_fail_count), .wd_state(wd_state));

  // pulses are caught here so a one-cycle event is never missed
  always @(posedge clk) begin
    if (spi_fail_pulse === 1'b1) spi_seen <= 1'b1;
    if (watchdog_fail_count_pulse === 1'b1) fail_seen <= 1'b1;
    if (soft_reset_pulse === 1'b1) soft_seen <= 1'b1;
    // the outside drops both disable bits on the pulse, as its sequencer would
    if (stop_disable_clear === 1'b1) begin
      clr_seen <= 1'b1;
      stop_dis <= 2'h0;
    end
  end
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : chk

  task automatic ticks(input int k);
    repeat (k) @(negedge clk);
  endtask : ticks

  // bounded wait on a failure pulse or on reset release
  task automatic until_flag(input logic want_fail, output int c);
    c = 0;
    while ((want_fail ? fail_seen : reset_out_n) !== 1'b1 && c < 9000) begin
      @(negedge clk);
      c++;
    end
  endtask : until_flag

  task automatic mode_cmd();
    soft_seen = 1'b0;
    @(posedge clk);
    mode_wr_valid <= 1'b1;
    mode_wr_field <= 2'h3;
    @(posedge clk);
    mode_wr_valid <= 1'b0;
    mode_wr_field <= 2'h0;
    ticks(3);
  endtask : mode_cmd

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ****************
  // sequence
  // ****************
  initial begin
    spi_seen = 1'b0; fail_seen = 1'b0; soft_seen = 1'b0; clr_seen = 1'b0;
    ticks(1);
    chk(reset_out_n, 0, "reset pin during reset");
    chk(watchdog_period_field, 3, "default period");
    chk(wd_state, svw_pkg::WD_OFF, "watchdog off in reset");
    @(posedge clk);
    rst <= 1'b0;
    until_flag(1'b0, n);
    chk(16'(n >= RDC && n <= RDC + 12), 1, "power-up release delay");
    ticks(2);
    chk(wd_state, svw_pkg::WD_LONG, "long window after release");
    foreach (rows[i]) begin
      spi_seen = 1'b0;
      host.serve(rows[i].pay, rows[i].bad);
      ticks(8);
      chk(watchdog_period_field, rows[i].per, "period setting");
      chk(spi_seen, rows[i].bad, "parity refusal");
    end
    fail_seen = 1'b0;
    host.serve(7'h00, 1'b0);
    until_flag(1'b1, n);
    chk(16'(n >= 10 * MSC && n <= 10 * MSC + 15), 1, "time-out expiry");
    chk(watchdog_fail_count, 1, "fail count");
    chk(watchdog_fail_count_restart, 1, "restart choice");
    ticks(1);
    chk(reset_out_n, 0, "reset on failure");
    fail_config <= 2'h1;
    until_flag(1'b0, n);
    chk(16'(n >= RDC - 4 && n <= RDC + 10), 1, "failure release delay");
    fail_seen = 1'b0;
    until_flag(1'b1, n);
    chk(16'(n >= LWC && n <= LWC + 10), 1, "long window length");
    chk(watchdog_fail_count, 1, "fail count saturation");
    until_flag(1'b0, n);
    fail_seen = 1'b0;
    host.serve(7'h10, 1'b0);
    ticks(8);
    chk(watchdog_fail_count, 0, "count cleared by trigger");
    chk(watchdog_type_select, 1, "window type");
    // host keeps to the safe trigger band of the window
    repeat (70) @(posedge clk);
    host.serve(7'h10, 1'b0);
    ticks(8);
    chk(fail_seen, 0, "open window trigger");
    restart_on_fail <= 1'b0;
    host.serve(7'h10, 1'b0);
    ticks(10);
    chk(fail_seen, 1, "closed window trigger");
    chk(watchdog_fail_count_restart, 0, "fail-safe choice");
    until_flag(1'b0, n);
    dev_mode <= svw_pkg::MODE_SLEEP;
    mode_cmd();
    chk(soft_seen, 0, "soft reset refused");
    chk(wd_state, svw_pkg::WD_OFF, "off in sleep");
    chk(watchdog_fail_count, 0, "count cleared in sleep");
    dev_mode <= svw_pkg::MODE_NORMAL;
    soft_reset_pulses_rst <= 1'b0;
    ticks(3);
    chk(wd_state, svw_pkg::WD_LONG, "long window on normal entry");
    mode_cmd();
    chk(soft_seen, 1, "soft reset in normal");
    chk(reset_out_n, 1, "soft reset without pin");
    chk({watchdog_type_select, watchdog_period_field}, 4'h3, "defaults");
    dev_mode <= svw_pkg::MODE_STOP;
    soft_reset_pulses_rst <= 1'b1;
    mode_cmd();
    chk({soft_seen, reset_out_n}, 2'h2, "soft reset pulses pin");
    until_flag(1'b0, n);
    chk(16'(n >= RDC - 4 && n <= RDC + 4), 1, "soft reset delay");
    stop_dis <= 2'h3;
    ticks(3);
    chk(wd_state, svw_pkg::WD_OFF, "off when stop-disabled");
    clr_seen = 1'b0;
    host.serve(7'h03, 1'b0);
    ticks(8);
    chk({clr_seen, wd_state}, {1'b1, svw_pkg::WD_LONG}, "stop trigger restarts");
    stop_dis <= 2'h3;
    clr_seen = 1'b0;
    ticks(3);
    dev_mode <= svw_pkg::MODE_NORMAL;
    ticks(3);
    chk({clr_seen, wd_state}, {1'b1, svw_pkg::WD_LONG}, "normal entry restarts");
    dev_mode <= svw_pkg::MODE_DEV;
    ticks(3);
    chk(wd_state, svw_pkg::WD_OFF, "off in development");
    dev_mode <= svw_pkg::MODE_NORMAL;
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (3) @(posedge clk);
    supply_low <= 1'b0;
    ticks(20);
    chk(reset_out_n, 1, "short dip filtered");
    @(posedge clk);
    supply_low <= 1'b1;
    ticks(30);
    chk(reset_out_n, 0, "undervoltage reset");
    @(posedge clk);
    supply_low <= 1'b0;
    until_flag(1'b0, n);
    chk(16'(n >= RDC && n <= RDC + 14), 1, "undervoltage release delay");
    stop_test();
  end

  initial begin
    #200000;
    failures++;
    stop_test();
  end
endmodule : svw_watchdog_tb
